// file: verilog/asba_pkg.sv
package asba_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  // power-up wait, 1 ms
  localparam longint unsigned POWER_WAIT_PS = 64'd1000000000;
  localparam int unsigned POWER_WAIT_CYC = int'((POWER_WAIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // write, read and float timing, ps
  localparam int unsigned WRITE_TO_FLOAT_DELAY_PS = 5000;
  localparam int unsigned DATA_SETUP_TIME_PS = 5500;
  localparam int unsigned WE_PULSE_PS = 7000;
  localparam int unsigned READ_CYCLE_PS = 10000;
  localparam int unsigned FLOAT_PS = 5000;
  // cycle counts, least times round up
  localparam int unsigned WR_MIN_PS = (WRITE_TO_FLOAT_DELAY_PS + DATA_SETUP_TIME_PS) > WE_PULSE_PS ?
                                      (WRITE_TO_FLOAT_DELAY_PS + DATA_SETUP_TIME_PS) : WE_PULSE_PS;
  localparam int unsigned WR_CYC = (WR_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RD_CYC = (READ_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FLOAT_CYC = (FLOAT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] WR_CYC_8 = 8'(WR_CYC);
  localparam logic [7:0] RD_CYC_8 = 8'(RD_CYC);
  localparam logic [7:0] FLOAT_CYC_8 = 8'(FLOAT_CYC);
  localparam int unsigned CNT_W = 20;
  // controller states
  typedef enum logic [2:0] {
    ASBA_POWER = 3'b000,
    ASBA_IDLE = 3'b001,
    ASBA_RD = 3'b010,
    ASBA_WR = 3'b011,
    ASBA_WR_END = 3'b100,
    ASBA_TURN = 3'b101
  } asba_state_t;
endpackage : asba_pkg

// file: verilog/asba_counter.sv
`timescale 1ns/100ps
// down counter: loads a value, then counts to zero
module asba_counter #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_value,
  // status
  output logic zero
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // load wins; otherwise step down and stop at zero
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign zero = (count == '0);
endmodule : asba_counter

// file: verilog/asba_ctrl.sv
`timescale 1ns/100ps
// host controller for a 1M x 16 asynchronous static memory
module asba_ctrl #(
  parameter int unsigned POWER_WAIT = asba_pkg::POWER_WAIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [asba_pkg::ADDR_W-1:0] req_addr,
  input wire logic [asba_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  // user answer
  output logic rsp_valid,
  output logic [asba_pkg::DATA_W-1:0] rsp_rdata,
  // memory pins
  output logic chip_select_n,
  output logic chip_select,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic low_byte_select_n,
  output logic high_byte_select_n,
  output logic [asba_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [asba_pkg::DATA_W-1:0] mem_data_in,
  output logic [asba_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  asba_pkg::asba_state_t state;
  asba_pkg::asba_state_t next_state;
  logic [asba_pkg::CNT_W-1:0] power_count;
  logic [asba_pkg::CNT_W-1:0] next_power_count;
  logic [asba_pkg::ADDR_W-1:0] next_mem_addr;
  logic [asba_pkg::DATA_W-1:0] next_mem_data_out;
  logic [asba_pkg::DATA_W-1:0] next_rsp_rdata;
  logic next_rsp_valid;
  logic [1:0] lanes_n;
  logic [1:0] next_lanes_n;
  logic chip_sel_act;
  logic next_chip_sel_act;
  logic we_act;
  logic next_we_act;
  logic oe_act;
  logic next_oe_act;
  logic drive;
  logic next_drive;
  logic timer_load;
  logic [7:0] timer_value;
  logic timer_zero;

  // ----------------------------------------
  // phase timer
  // ----------------------------------------
  asba_counter #(.W(8)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_value(timer_value),
    .zero(timer_zero)
  );

  assign req_ready = (state == asba_pkg::ASBA_IDLE);

  // sequencer: each access holds its strobes for whole timer periods
  always_comb begin
    next_state = state;
    next_power_count = power_count;
    next_mem_addr = mem_addr;
    next_mem_data_out = mem_data_out;
    next_rsp_rdata = rsp_rdata;
    next_rsp_valid = 1'b0;
    next_lanes_n = lanes_n;
    next_chip_sel_act = chip_sel_act;
    next_we_act = we_act;
    next_oe_act = oe_act;
    next_drive = drive;
    timer_load = 1'b0;
    timer_value = 8'h00;
    unique case (state)
      asba_pkg::ASBA_POWER: begin
        // no access until the supply has settled
        if (power_count == asba_pkg::CNT_W'(POWER_WAIT - 1)) begin
          next_state = asba_pkg::ASBA_IDLE;
        end else begin
          next_power_count = power_count + asba_pkg::CNT_W'(1);
        end
      end
      asba_pkg::ASBA_IDLE: begin
        if (req_valid && req_lanes != 2'b00) begin
          // address set up together with chip selects, never after
          next_mem_addr = req_addr;
          next_lanes_n = ~req_lanes;
          next_chip_sel_act = 1'b1;
          timer_load = 1'b1;
          if (req_write) begin
            next_mem_data_out = req_wdata;
            next_we_act = 1'b1;
            next_drive = 1'b1;
            next_state = asba_pkg::ASBA_WR;
            timer_value = asba_pkg::WR_CYC_8;
          end else begin
            next_oe_act = 1'b1;
            next_state = asba_pkg::ASBA_RD;
            timer_value = asba_pkg::RD_CYC_8;
          end
        end
      end
      asba_pkg::ASBA_RD: begin
        if (timer_zero) begin
          next_rsp_rdata = mem_data_in;
          next_rsp_valid = 1'b1;
          next_chip_sel_act = 1'b0;
          next_oe_act = 1'b0;
          next_lanes_n = 2'b11;
          timer_load = 1'b1;
          timer_value = asba_pkg::FLOAT_CYC_8;
          next_state = asba_pkg::ASBA_TURN;
        end
      end
      asba_pkg::ASBA_WR: begin
        // write strobe alone ends the write; data stays one more cycle
        if (timer_zero) begin
          next_we_act = 1'b0;
          next_state = asba_pkg::ASBA_WR_END;
        end
      end
      asba_pkg::ASBA_WR_END: begin
        next_drive = 1'b0;
        next_chip_sel_act = 1'b0;
        next_lanes_n = 2'b11;
        next_rsp_valid = 1'b1;
        next_state = asba_pkg::ASBA_IDLE;
      end
      asba_pkg::ASBA_TURN: begin
        // memory output float time before anyone drives again
        if (timer_zero) begin
          next_state = asba_pkg::ASBA_IDLE;
        end
      end
      default: begin
        next_state = asba_pkg::ASBA_POWER;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= asba_pkg::ASBA_POWER;
      power_count <= '0;
      mem_addr <= '0;
      mem_data_out <= '0;
      rsp_rdata <= '0;
      rsp_valid <= 1'b0;
      lanes_n <= 2'b11;
      chip_sel_act <= 1'b0;
      we_act <= 1'b0;
      oe_act <= 1'b0;
      drive <= 1'b0;
    end else begin
      state <= next_state;
      power_count <= next_power_count;
      mem_addr <= next_mem_addr;
      mem_data_out <= next_mem_data_out;
      rsp_rdata <= next_rsp_rdata;
      rsp_valid <= next_rsp_valid;
      lanes_n <= next_lanes_n;
      chip_sel_act <= next_chip_sel_act;
      we_act <= next_we_act;
      oe_act <= next_oe_act;
      drive <= next_drive;
    end
  end

  // pins straight from flip-flops, so no glitches reach the memory
  assign chip_select_n = ~chip_sel_act;
  assign chip_select = chip_sel_act;
  assign write_strobe_n = ~we_act;
  assign output_drive_n = ~oe_act;
  assign low_byte_select_n = lanes_n[0];
  assign high_byte_select_n = lanes_n[1];
  assign mem_data_oe = drive;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_no_early_access;
    @(posedge clk) disable iff (!rst_n) (state == asba_pkg::ASBA_POWER) |-> !chip_sel_act;
  endproperty
  a_no_early_access: assert property (p_no_early_access) else $error("access during power wait");

  property p_write_start;
    @(posedge clk) disable iff (!rst_n) $rose(we_act) |-> chip_sel_act && (lanes_n != 2'b11);
  endproperty
  a_write_start: assert property (p_write_start) else $error("write started without select");

  property p_write_length;
    @(posedge clk) disable iff (!rst_n) $rose(we_act) |-> we_act [*3];
  endproperty
  a_write_length: assert property (p_write_length) else $error("write pulse too short");

  property p_data_hold;
    @(posedge clk) disable iff (!rst_n) $fell(we_act) |-> drive && $stable(mem_data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data dropped at write end");

  property p_no_contention;
    @(posedge clk) disable iff (!rst_n) oe_act |-> !drive && !we_act;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus driven during read");

  property p_read_we_high;
    @(posedge clk) disable iff (!rst_n) (state == asba_pkg::ASBA_RD) |-> write_strobe_n;
  endproperty
  a_read_we_high: assert property (p_read_we_high) else $error("strobe low in read");

  property p_addr_stable;
    @(posedge clk) disable iff (!rst_n) chip_sel_act && $past(chip_sel_act) |-> $stable(mem_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected");

  property p_turnaround;
    @(posedge clk) disable iff (!rst_n) $fell(oe_act) |-> !drive [*2];
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("drive too soon after read");

  property p_read_answer;
    @(posedge clk) disable iff (!rst_n) $rose(oe_act) |-> ##[3:4] rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  c_read: cover property (@(posedge clk) disable iff (!rst_n) $rose(oe_act) ##[1:8] rsp_valid);
  c_write: cover property (@(posedge clk) disable iff (!rst_n) $fell(we_act) ##1 rsp_valid);
  c_low_only: cover property (@(posedge clk) disable iff (!rst_n) we_act && lanes_n == 2'b10);
endmodule : asba_ctrl

// file: verification/asba_sram_model.sv
`timescale 1ns/100ps
// -----------------------------
// behavioural static memory
// -----------------------------
module asba_sram_model (
  // control pins
  input wire logic chip_select_n,
  input wire logic chip_select,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic low_byte_select_n,
  input wire logic high_byte_select_n,
  // address and data
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic [1:0] lane_drive
);
  logic [15:0] mem [bit [19:0]]; // sparse, one word per address
  logic [15:0] cur;
  logic sel;
  logic wr;
  logic [1:0] lane_n;
  // deselected means standby: nothing else matters
  assign lane_n = {high_byte_select_n, low_byte_select_n};
  assign sel = !chip_select_n && chip_select;
  assign wr = sel && !write_strobe_n && (lane_n != 2'b11);
  // lanes float on output drive high, byte select high or a write
  assign lane_drive = (sel && !output_drive_n && write_strobe_n) ? ~lane_n : 2'b00;
  // unwritten words read as inverted address so stale data never matches
  always @(addr or output_drive_n or write_strobe_n or chip_select_n) begin
    rdata = mem.exists(addr) ? mem[addr] : ~addr[15:0];
  end
  // the word follows the bus during the whole overlap, last value stands
  always @(wr or wdata or lane_n or addr) begin
    if (wr) begin
      cur = mem.exists(addr) ? mem[addr] : ~addr[15:0];
      if (!lane_n[0]) cur[7:0] = wdata[7:0];
      if (!lane_n[1]) cur[15:8] = wdata[15:8];
      mem[addr] = cur;
    end
  end
endmodule : asba_sram_model

// file: verification/asba_ctrl_test.sv
`timescale 1ns/100ps
module asba_ctrl_test;
  localparam int unsigned PW = 20;
  logic clk, rst_n, req_valid, req_ready, req_write, rsp_valid;
  logic cs_n, cs, od_n, we_n, lb_n, hb_n, oe;
  logic [19:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rsp_rdata, din, dout, rd, drv_mask, exp;
  logic [1:0] req_lanes, drv;
  int num_errors, n_tests;
  // -----------------------------
  // clock, design and memory
  // -----------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  asba_ctrl #(.POWER_WAIT(PW)) dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .chip_select_n(cs_n), .chip_select(cs),
    .output_drive_n(od_n), .write_strobe_n(we_n), .low_byte_select_n(lb_n), .high_byte_select_n(hb_n),
    .mem_addr(mem_addr), .mem_data_in(din), .mem_data_out(dout), .mem_data_oe(oe));
  asba_sram_model mem (.chip_select_n(cs_n), .chip_select(cs), .output_drive_n(od_n), .write_strobe_n(we_n),
    .low_byte_select_n(lb_n), .high_byte_select_n(hb_n), .addr(mem_addr), .wdata(din), .rdata(rd),
    .lane_drive(drv));
  // a floating lane shows the inverse of the stored byte, never a lucky match
  assign drv_mask = {{8{drv[1]}}, {8{drv[0]}}};
  assign din = oe ? dout : ((rd & drv_mask) | (~rd & ~drv_mask));
  // -----------------------------
  // checks and verdict
  // -----------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] want, input logic [15:0] mask);
    n_tests++;
    if ((got & mask) !== (want & mask)) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & mask, want & mask);
    end
  endtask : cmp
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic wait_ready();
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k >= 100) begin
      cmp(16'h0, 16'h1, 16'h1);
      print_verdict();
    end
  endtask : wait_ready
  // bus contention and the write strobe in reads, every cycle
  always @(posedge clk) begin
    if (rst_n && oe && drv != 2'b00) cmp({14'h0, drv}, 16'h0, 16'h3);
    if (rst_n && !cs_n && !od_n) cmp({15'h0, we_n}, 16'h1, 16'h1);
  end
  // one request, held until taken; pins checked one cycle in
  task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d, input logic [1:0] ln);
    int k;
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, wr, a, d, ln};
    wait_ready();
    @(negedge clk);
    req_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
      if (k == 1) cmp({cs_n, cs, we_n, hb_n, lb_n, mem_addr[10:0]}, {2'b01, ~wr, ~ln, a[10:0]}, 16'hffff);
    end
    // load cycle plus timer counts; a write also holds data one cycle past the strobe
    cmp(16'(k), wr ? 16'(asba_pkg::WR_CYC + 2) : 16'(asba_pkg::RD_CYC + 1), 16'hffff);
    if (k >= 50) print_verdict();
    if (!wr) cmp(rsp_rdata, exp, drv_mask | {{8{ln[1]}}, {8{ln[0]}}});
  endtask : access
  // -----------------------------
  // scenarios
  // -----------------------------
  task automatic t_power();
    int k;
    {req_valid, req_lanes} = 3'b111;
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
      cmp({15'h0, cs_n}, 16'h1, 16'h1);
    end
    cmp({15'h0, k >= PW - 1 && k <= PW + 2}, 16'h1, 16'h1);
    if (k >= 100) print_verdict();
    req_valid = 1'b0;
  endtask : t_power
  task automatic t_lanes();
    logic [15:0] d;
    exp = 16'h5a5a;
    access(1'b1, 20'h12345, exp, 2'b11);
    for (int l = 1; l <= 3; l++) begin
      d = 16'(32'h8421 * l);
      if (l[0]) exp[7:0] = d[7:0];
      if (l[1]) exp[15:8] = d[15:8];
      access(1'b1, 20'h12345, d, 2'(l));
      access(1'b0, 20'h12345, 16'h0, 2'(l));
      access(1'b0, 20'h12345, 16'h0, 2'b11);
    end
  endtask : t_lanes
  task automatic t_refuse();
    @(negedge clk);
    {req_valid, req_write, req_lanes} = 4'b1100;
    // the last read may still be in its turnaround, so let idle come first
    wait_ready();
    repeat (8) begin
      @(negedge clk);
      cmp({14'h0, cs_n, req_ready}, 16'h3, 16'h3);
    end
    req_valid = 1'b0;
  endtask : t_refuse
  task automatic t_bounds();
    access(1'b1, 20'hfffff, 16'hbeef, 2'b11);
    access(1'b1, 20'h00000, 16'h1c0d, 2'b11);
    exp = 16'hbeef;
    access(1'b0, 20'hfffff, 16'h0, 2'b11);
    exp = 16'h1c0d;
    access(1'b0, 20'h00000, 16'h0, 2'b11);
  endtask : t_bounds
  initial begin
    {rst_n, req_valid, req_write, req_addr, req_wdata, req_lanes} = '0;
    {num_errors, n_tests} = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_power();
    t_lanes();
    t_refuse();
    t_bounds();
    print_verdict();
  end
endmodule : asba_ctrl_test
